// *** bench/amp_i2c_control_port_checker.sv ***
`timescale 1ns/1ps
module amp_i2c_control_port_checker
(
    input wire logic                     clk_sys,
    input wire logic                     sys_rst,
    input wire logic                     sclIn,
    input wire logic                     sdaIn,
    input wire logic                     sdaOut,
    input wire logic                     sdaOe,
    input wire logic                     sleep_or_addr_select_pin,
    input wire amp_i2c_pkg::faultFlags_t faultFlags,
    input wire amp_i2c_pkg::ctrlRegs_t   ctrlRegs,
    input wire logic [6:0]               targetAddr
);
    // ****************
    // Helper state
    // ****************
    logic [1:0] sinceRst;
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
            sinceRst <= 2'h0;
        else if (sinceRst != 2'h3)
            sinceRst <= sinceRst + 2'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence startSeen;
        sclIn && $past(sclIn) && $fell(sdaIn);
    endsequence
    sequence stopSeen;
        sclIn && $past(sclIn) && $rose(sdaIn);
    endsequence
    // ****************
    // Assertions
    // ****************
    drive_zero_a: assert property (sdaOut == 1'b0)
        else $error("data drive value not low");
    addr_upper_a: assert property (targetAddr[6:1] == 6'h36)
        else $error("fixed address bits wrong");
    addr_latch_a: assert property (sinceRst == 2'h1 |->
        targetAddr[0] == $past(sleep_or_addr_select_pin)) else $error("strap not latched");
    addr_stable_a: assert property (sinceRst >= 2'h2 |-> $stable(targetAddr))
        else $error("address changed after latch");
    oe_low_phase_a: assert property ($changed(sdaOe) |-> !sclIn && !$past(sclIn))
        else $error("data drive changed outside clock low");
    oe_hold_high_a: assert property (sclIn && $past(sclIn) |-> sdaOe == $past(sdaOe))
        else $error("data drive moved during clock high");
    start_release_a: assert property (startSeen |=> !sdaOe [*8])
        else $error("data driven right after start");
    stop_release_a: assert property (stopSeen |=> !sdaOe [*8])
        else $error("data driven right after stop");
    regs_low_phase_a: assert property ($changed(ctrlRegs) |-> !sclIn)
        else $error("registers changed during clock high");
    reserved_bits_a: assert property (ctrlRegs.digitalPath[6] == 1'b0 &&
        ctrlRegs.volumeConfig[6:2] == 5'h0 && ctrlRegs.analogControl[0] == 1'b1)
        else $error("reserved register bits changed");
endmodule : amp_i2c_control_port_checker

bind amp_i2c_control_port amp_i2c_control_port_checker amp_i2c_control_port_checker_inst
(
    .clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .sleep_or_addr_select_pin(sleep_or_addr_select_pin),
    .faultFlags(faultFlags), .ctrlRegs(ctrlRegs), .targetAddr(targetAddr)
);

// *** bench/i2c_master_model.sv ***
`timescale 1ns/1ps
module i2c_master_model
(
    input  wire logic clk_sys,
    input  wire logic sdaWire,
    output logic      sclOut,
    output logic      sdaPull
);
    int half = 8;
    initial
    begin
        sclOut = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic start();
        sdaPull = 1'b0;
        tick(half);
        sclOut = 1'b1;
        tick(half);
        sdaPull = 1'b1;
        tick(half);
        sclOut = 1'b0;
    endtask : start
    task automatic stop();
        tick(half / 2);
        sdaPull = 1'b1;
        tick(half / 2);
        sclOut = 1'b1;
        tick(half);
        sdaPull = 1'b0;
        tick(half);
    endtask : stop
    task automatic bitio(input logic b, output logic r);
        tick(half / 2);
        sdaPull = !b;
        tick(half - half / 2);
        sclOut = 1'b1;
        tick(half / 2);
        r = sdaWire;
        tick(half - half / 2);
        sclOut = 1'b0;
    endtask : bitio
    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitio(b[i], r);
        bitio(1'b1, r);
        ack = !r;
    endtask : sendByte
    task automatic recvByte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bitio(1'b1, r);
            d[i] = r;
        end
        bitio(nack, r);
    endtask : recvByte
endmodule : i2c_master_model

// *** bench/tb.sv ***
`timescale 1ns/1ps
`define CHECK(g, e) begin nCompared++; if ((g) !== (e)) begin errCount++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb;
    localparam logic [7:0] PART = 8'h5A; // Arbitrary identity value
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic strap = 1'b0;
    amp_i2c_pkg::faultFlags_t flags = 4'h0;
    amp_i2c_pkg::ctrlRegs_t regs;
    logic [6:0] addr;
    logic sdaOe, sdaOut, scl, mPull, sda;
    int errCount = 0;
    int nCompared = 0;
    int cycles = 0;
    assign sda = (sdaOe ? sdaOut : 1'b1) && !mPull;
    always #4 clk_sys = ~clk_sys;
    amp_i2c_control_port #(.PART_ID(PART)) amp_i2c_control_port_inst
    (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .sleep_or_addr_select_pin(strap), .faultFlags(flags),
        .ctrlRegs(regs), .targetAddr(addr)
    );
    i2c_master_model i2c_master_model_inst
    (
        .clk_sys(clk_sys), .sdaWire(sda), .sclOut(scl), .sdaPull(mPull)
    );
    task automatic giveVerdict();
        $display("compared %0d mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : giveVerdict
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 80000)
        begin
            errCount++;
            giveVerdict();
        end
    end
    task automatic head(input logic [7:0] idx);
        logic a;
        i2c_master_model_inst.start();
        i2c_master_model_inst.sendByte(8'hD8, a);
        `CHECK(a, 1'b1)
        i2c_master_model_inst.sendByte(idx, a);
        `CHECK(a, 1'b1)
    endtask : head
    task automatic wr(input logic [7:0] idx, input logic [7:0] d [$]);
        logic a;
        head(idx);
        foreach (d[i])
        begin
            i2c_master_model_inst.sendByte(d[i], a);
            `CHECK(a, 1'b1)
        end
        i2c_master_model_inst.stop();
    endtask : wr
    task automatic rd(input logic [7:0] idx, input logic [7:0] e [$]);
        logic a;
        logic [7:0] v;
        head(idx);
        i2c_master_model_inst.start();
        i2c_master_model_inst.sendByte(8'hD9, a);
        `CHECK(a, 1'b1)
        foreach (e[i])
        begin
            i2c_master_model_inst.recvByte(i == e.size() - 1, v);
            `CHECK(v, e[i])
        end
        i2c_master_model_inst.stop();
    endtask : rd
    task automatic testReset();
        amp_i2c_pkg::ctrlRegs_t exp;
        exp = '{8'hFD, 8'h14, 8'h80, 8'hCF, 8'hCF, 8'h51, 2'h0, 8'hFF, 8'hFC};
        `CHECK(regs, exp)
        `CHECK(addr, 7'h6C)
        strap = 1'b1;
        $display("testReset done");
    endtask : testReset
    task automatic testRates();
        i2c_master_model_inst.half = 625;
        wr(8'h04, '{8'h3C});
        `CHECK(regs.leftVolume, 8'h3C)
        i2c_master_model_inst.half = 157;
        rd(8'h04, '{8'h3C});
        $display("testRates done");
    endtask : testRates
    task automatic testBurst();
        i2c_master_model_inst.half = 8;
        wr(8'h10, '{8'h12, 8'h34});
        `CHECK(regs.clipMid, 8'h12)
        `CHECK(regs.clipLow, 8'h34)
        rd(8'h10, '{8'h12, 8'h34});
        $display("testBurst done");
    endtask : testBurst
    task automatic testMasks();
        wr(8'h02, '{8'hFF, 8'hFF});
        `CHECK(regs.digitalPath, 8'hBF)
        `CHECK(regs.volumeConfig, 8'h83)
        wr(8'h06, '{8'h00, 8'h00, 8'h30});
        `CHECK(regs.analogControl, 8'h01)
        flags = 4'hA;
        wr(8'h00, '{8'h11, 8'hA5});
        `CHECK(regs.powerClipHigh, 8'hA5)
        rd(8'h00, '{PART});
        rd(8'h07, '{8'h00, 8'h3A});
        rd(8'h20, '{8'h00});
        $display("testMasks done");
    endtask : testMasks
    task automatic testMismatch();
        logic a;
        i2c_master_model_inst.start();
        i2c_master_model_inst.sendByte(8'hDA, a);
        `CHECK(a, 1'b0)
        i2c_master_model_inst.sendByte(8'h04, a);
        `CHECK(a, 1'b0)
        i2c_master_model_inst.stop();
        head(8'h05);
        i2c_master_model_inst.bitio(1'b0, a);
        i2c_master_model_inst.bitio(1'b0, a);
        i2c_master_model_inst.stop();
        `CHECK(regs.rightVolume, 8'hCF)
        `CHECK(regs.leftVolume, 8'h3C)
        $display("testMismatch done");
    endtask : testMismatch
    task automatic testStrap();
        logic a;
        logic [7:0] v;
        sys_rst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        `CHECK(addr, 7'h6D)
        `CHECK(regs.leftVolume, 8'hCF)
        i2c_master_model_inst.start();
        i2c_master_model_inst.sendByte(8'hDA, a);
        `CHECK(a, 1'b1)
        i2c_master_model_inst.sendByte(8'h05, a);
        `CHECK(a, 1'b1)
        i2c_master_model_inst.sendByte(8'h66, a);
        `CHECK(a, 1'b1)
        i2c_master_model_inst.start();
        i2c_master_model_inst.sendByte(8'hDB, a);
        `CHECK(a, 1'b1)
        i2c_master_model_inst.recvByte(1'b1, v);
        `CHECK(v, 8'h51)
        i2c_master_model_inst.stop();
        `CHECK(regs.rightVolume, 8'h66)
        $display("testStrap done");
    endtask : testStrap
    initial
    begin
        repeat (3) @(posedge clk_sys);
        #1 sys_rst = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        testReset();
        testRates();
        testBurst();
        testMasks();
        testMismatch();
        testStrap();
        giveVerdict();
    end
endmodule : tb

// *** design/amp_i2c_control_port.sv ***
`timescale 1ns/1ps
`include "amp_i2c_regs.svh"

module amp_i2c_control_port
#(
    parameter int unsigned CLK_HZ  = `SYS_CLK_HZ,
    parameter logic [7:0]  PART_ID = 8'h5A  // Arbitrary identity value
)
(
    input  wire logic                      clk_sys,
    input  wire logic                      sys_rst,
    input  wire logic                      sclIn,
    input  wire logic                      sdaIn,
    output wire logic                      sdaOut,
    output logic                           sdaOe,
    input  wire logic                      sleep_or_addr_select_pin,
    input  wire amp_i2c_pkg::faultFlags_t  faultFlags,
    output amp_i2c_pkg::ctrlRegs_t         ctrlRegs,
    output logic [6:0]                     targetAddr
);

    // ********************************************************
    // Elaboration check
    // ********************************************************
    if (CLK_HZ < `FAST_SCL_HZ * `MIN_OVERSAMPLE)
    begin : gClkCheck
        $error("System clock too slow for fast-mode bus");
    end

    // ********************************************************
    // Declarations
    // ********************************************************
    amp_i2c_pkg::portState_t  state;
    amp_i2c_pkg::bytePhase_t  phase;
    logic                     sclQ;
    logic                     sdaQ;
    logic                     sclRise;
    logic                     sclFall;
    logic                     startSeen;
    logic                     stopSeen;
    logic [3:0]               bitCnt;
    logic [7:0]               shiftReg;
    logic [7:0]               regIndex;
    logic                     readDir;
    logic                     masterNack;
    logic                     addrLatched;
    logic                     addrLow;
    logic                     byteDone;
    logic                     addrMatch;
    logic                     wrEn;
    logic [7:0]               readData;

    // Open-drain: only ever pulls low
    assign sdaOut = 1'b0;

    // ********************************************************
    // Bus condition detection
    // ********************************************************
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sclQ <= 1'b1;
            sdaQ <= 1'b1;
        end
        else
        begin
            sclQ <= sclIn;
            sdaQ <= sdaIn;
        end
    end

    assign sclRise   = sclIn & ~sclQ;
    assign sclFall   = ~sclIn & sclQ;
    assign startSeen = sclIn & sclQ & sdaQ & ~sdaIn;
    assign stopSeen  = sclIn & sclQ & ~sdaQ & sdaIn;

    // ********************************************************
    // Target address latch
    // ********************************************************
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            addrLatched <= 1'b0;
            addrLow     <= 1'b0;
        end
        else if (!addrLatched)
        begin
            addrLatched <= 1'b1;
            addrLow     <= sleep_or_addr_select_pin;
        end
    end

    assign targetAddr = {`TARGET_ADDR_HI, addrLow};
    assign byteDone   = (state == amp_i2c_pkg::ST_RECV) && sclFall
                        && (bitCnt == `BYTE_LAST_BIT);
    assign addrMatch  = (shiftReg[7:1] == targetAddr);
    assign wrEn       = byteDone && (phase == amp_i2c_pkg::PH_DATA);

    // ********************************************************
    // Protocol engine
    // ********************************************************
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state      <= amp_i2c_pkg::ST_IDLE;
            phase      <= amp_i2c_pkg::PH_ADDR;
            bitCnt     <= 4'h0;
            shiftReg   <= 8'h00;
            regIndex   <= 8'h00;
            readDir    <= 1'b0;
            masterNack <= 1'b0;
            sdaOe      <= 1'b0;
        end
        else if (startSeen)
        begin
            // Start or repeated start; index is kept for reads
            state  <= amp_i2c_pkg::ST_RECV;
            phase  <= amp_i2c_pkg::PH_ADDR;
            bitCnt <= 4'h0;
            sdaOe  <= 1'b0;
        end
        else if (stopSeen)
        begin
            state <= amp_i2c_pkg::ST_IDLE;
            sdaOe <= 1'b0;
        end
        else
        begin
            case (state)
                amp_i2c_pkg::ST_IDLE:
                begin
                    sdaOe <= 1'b0;
                end
                amp_i2c_pkg::ST_RECV:
                begin
                    if (sclRise && bitCnt < `BYTE_LAST_BIT)
                    begin
                        shiftReg <= {shiftReg[6:0], sdaIn};
                        bitCnt   <= bitCnt + 4'h1;
                    end
                    else if (byteDone)
                    begin
                        case (phase)
                            amp_i2c_pkg::PH_ADDR:
                            begin
                                if (addrMatch)
                                begin
                                    readDir <= shiftReg[0];
                                    state   <= amp_i2c_pkg::ST_ACK;
                                    sdaOe   <= 1'b1;
                                end
                                else
                                begin
                                    state <= amp_i2c_pkg::ST_IDLE;
                                end
                            end
                            amp_i2c_pkg::PH_INDEX:
                            begin
                                regIndex <= shiftReg;
                                phase    <= amp_i2c_pkg::PH_DATA;
                                state    <= amp_i2c_pkg::ST_ACK;
                                sdaOe    <= 1'b1;
                            end
                            default:
                            begin
                                regIndex <= regIndex + 8'h01;
                                state    <= amp_i2c_pkg::ST_ACK;
                                sdaOe    <= 1'b1;
                            end
                        endcase
                    end
                end
                amp_i2c_pkg::ST_ACK:
                begin
                    // After the ninth clock falls, release, or on a read drive the first data bit
                    if (sclFall)
                    begin
                        bitCnt <= 4'h0;
                        if (phase == amp_i2c_pkg::PH_ADDR && readDir)
                        begin
                            shiftReg <= readData;
                            regIndex <= regIndex + 8'h01;
                            sdaOe    <= ~readData[7];
                            state    <= amp_i2c_pkg::ST_SEND;
                        end
                        else
                        begin
                            if (phase == amp_i2c_pkg::PH_ADDR)
                            begin
                                phase <= amp_i2c_pkg::PH_INDEX;
                            end
                            sdaOe <= 1'b0;
                            state <= amp_i2c_pkg::ST_RECV;
                        end
                    end
                end
                amp_i2c_pkg::ST_SEND:
                begin
                    if (sclFall)
                    begin
                        if (bitCnt[2:0] == `SEND_LAST_BIT)
                        begin
                            sdaOe <= 1'b0;
                            state <= amp_i2c_pkg::ST_MACK;
                        end
                        else
                        begin
                            shiftReg <= {shiftReg[6:0], 1'b0};
                            sdaOe    <= ~shiftReg[6];
                            bitCnt   <= bitCnt + 4'h1;
                        end
                    end
                end
                amp_i2c_pkg::ST_MACK:
                begin
                    if (sclRise)
                    begin
                        masterNack <= sdaIn;
                    end
                    else if (sclFall)
                    begin
                        if (masterNack)
                        begin
                            state <= amp_i2c_pkg::ST_IDLE;
                        end
                        else
                        begin
                            shiftReg <= readData;
                            regIndex <= regIndex + 8'h01;
                            sdaOe    <= ~readData[7];
                            bitCnt   <= 4'h0;
                            state    <= amp_i2c_pkg::ST_SEND;
                        end
                    end
                end
                default:
                begin
                    state <= amp_i2c_pkg::ST_IDLE;
                    sdaOe <= 1'b0;
                end
            endcase
        end
    end

    // ********************************************************
    // Register bank
    // ********************************************************
    always_ff @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrlRegs.powerClipHigh  <= `RST_POWER;
            ctrlRegs.digitalPath    <= `RST_DIGITAL;
            ctrlRegs.volumeConfig   <= `RST_VOL_CFG;
            ctrlRegs.leftVolume     <= `RST_VOLUME;
            ctrlRegs.rightVolume    <= `RST_VOLUME;
            ctrlRegs.analogControl  <= `RST_ANALOG;
            ctrlRegs.faultThreshold <= `RST_FAULT_THR;
            ctrlRegs.clipMid        <= `RST_CLIP_MID;
            ctrlRegs.clipLow        <= `RST_CLIP_LOW;
        end
        else if (wrEn)
        begin
            case (regIndex)
                `REG_POWER:
                begin
                    ctrlRegs.powerClipHigh <= shiftReg;
                end
                `REG_DIGITAL:
                begin
                    ctrlRegs.digitalPath <= (shiftReg & `MASK_DIGITAL)
                                            | (`RST_DIGITAL & ~`MASK_DIGITAL);
                end
                `REG_VOL_CFG:
                begin
                    ctrlRegs.volumeConfig <= (shiftReg & `MASK_VOL_CFG)
                                             | (`RST_VOL_CFG & ~`MASK_VOL_CFG);
                end
                `REG_LEFT_VOL:
                begin
                    ctrlRegs.leftVolume <= shiftReg;
                end
                `REG_RIGHT_VOL:
                begin
                    ctrlRegs.rightVolume <= shiftReg;
                end
                `REG_ANALOG:
                begin
                    ctrlRegs.analogControl <= (shiftReg & `MASK_ANALOG)
                                              | (`RST_ANALOG & ~`MASK_ANALOG);
                end
                `REG_FAULT:
                begin
                    ctrlRegs.faultThreshold <=
                        shiftReg[`FAULT_THR_MSB:`FAULT_THR_LSB];
                end
                `REG_CLIP_MID:
                begin
                    ctrlRegs.clipMid <= shiftReg;
                end
                `REG_CLIP_LOW:
                begin
                    ctrlRegs.clipLow <= shiftReg;
                end
                default:
                begin
                    ctrlRegs.clipLow <= ctrlRegs.clipLow;
                end
            endcase
        end
    end

    // ********************************************************
    // Read multiplexer
    // ********************************************************
    always_comb
    begin
        case (regIndex)
            `REG_IDENTITY:  readData = PART_ID;
            `REG_POWER:     readData = ctrlRegs.powerClipHigh;
            `REG_DIGITAL:   readData = ctrlRegs.digitalPath;
            `REG_VOL_CFG:   readData = ctrlRegs.volumeConfig;
            `REG_LEFT_VOL:  readData = ctrlRegs.leftVolume;
            `REG_RIGHT_VOL: readData = ctrlRegs.rightVolume;
            `REG_ANALOG:    readData = ctrlRegs.analogControl;
            `REG_FAULT:     readData = {2'h0, ctrlRegs.faultThreshold, faultFlags};
            `REG_CLIP_MID:  readData = ctrlRegs.clipMid;
            `REG_CLIP_LOW:  readData = ctrlRegs.clipLow;
            default:        readData = 8'h00;
        endcase
    end

endmodule : amp_i2c_control_port

// *** design/amp_i2c_pkg.sv ***
package amp_i2c_pkg;

    typedef enum logic [4:0]
    {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACK  = 5'h04,
        ST_SEND = 5'h08,
        ST_MACK = 5'h10
    } portState_t;

    typedef enum logic [1:0]
    {
        PH_ADDR  = 2'h0,
        PH_INDEX = 2'h1,
        PH_DATA  = 2'h2
    } bytePhase_t;

    typedef struct packed
    {
        logic [7:0] powerClipHigh;
        logic [7:0] digitalPath;
        logic [7:0] volumeConfig;
        logic [7:0] leftVolume;
        logic [7:0] rightVolume;
        logic [7:0] analogControl;
        logic [1:0] faultThreshold;
        logic [7:0] clipMid;
        logic [7:0] clipLow;
    } ctrlRegs_t;

    typedef struct packed
    {
        logic clockError;
        logic overCurrent;
        logic dcError;
        logic overTemp;
    } faultFlags_t;

endpackage : amp_i2c_pkg

// *** design/amp_i2c_regs.svh ***
`ifndef AMP_I2C_REGS_SVH
`define AMP_I2C_REGS_SVH

// ************************************************************
// Timing
// ************************************************************
`define SYS_CLK_HZ      125000000
`define STD_SCL_HZ      100000
`define FAST_SCL_HZ     400000
`define MIN_OVERSAMPLE  8

// ************************************************************
// Addressing
// ************************************************************
`define TARGET_ADDR_HI  6'h36
`define BYTE_LAST_BIT   4'h8
`define SEND_LAST_BIT   3'h7

// ************************************************************
// Register offsets
// ************************************************************
`define REG_IDENTITY    8'h00
`define REG_POWER       8'h01
`define REG_DIGITAL     8'h02
`define REG_VOL_CFG     8'h03
`define REG_LEFT_VOL    8'h04
`define REG_RIGHT_VOL   8'h05
`define REG_ANALOG      8'h06
`define REG_SPARE7      8'h07
`define REG_FAULT       8'h08
`define REG_CLIP_MID    8'h10
`define REG_CLIP_LOW    8'h11

// ************************************************************
// Reset values and writable masks
// ************************************************************
`define RST_POWER       8'hFD
`define RST_DIGITAL     8'h14
`define RST_VOL_CFG     8'h80
`define RST_VOLUME      8'hCF
`define RST_ANALOG      8'h51
`define RST_FAULT_THR   2'h0
`define RST_CLIP_MID    8'hFF
`define RST_CLIP_LOW    8'hFC
`define MASK_DIGITAL    8'hBF
`define MASK_VOL_CFG    8'h83
`define MASK_ANALOG     8'hFE
`define FAULT_THR_MSB   5
`define FAULT_THR_LSB   4

`endif
